// file: lcdc_driver.sv
`timescale 1ns/1ps
module lcdc_driver
  import lcdc_pkg::*;
#(
  parameter int BASE_DIV_CYCLES = BASE_DIV
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic        sleep_power_mode,
  output logic [7:0]       sfr_rdata,
  output lcdc_drive_type   drive,
  output lcdc_analog_type  analog
);

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0]          main_config_reg;
  logic [7:0]          clock_config_reg;
  logic [7:0]          seg_enable_a_reg;
  logic [7:0]          seg_enable_b_reg;
  logic [7:0]          config_x_reg;
  logic [7:0]          config_y_reg;
  logic [7:0]          mem_pointer_reg;
  logic [7:0]          mem_reg [MEM_BYTES];
  logic [MEM_BITS-1:0] shadow_reg;
  logic                frame_start;

  function automatic logic hit(input logic [7:0] a);
    return sfr_wr && (sfr_addr == a);
  endfunction : hit

  always_ff @(posedge clk) begin
    if (!resetn) begin
      main_config_reg  <= RESET_VALUE;
      clock_config_reg <= RESET_VALUE;
      seg_enable_a_reg <= RESET_VALUE;
      seg_enable_b_reg <= RESET_VALUE;
      config_x_reg     <= RESET_VALUE;
      mem_pointer_reg  <= RESET_VALUE;
    end else begin
      if (hit(ADDR_MAIN_CONFIG))  main_config_reg  <= sfr_wdata;
      if (hit(ADDR_CLOCK_CONFIG)) clock_config_reg <= sfr_wdata;
      if (hit(ADDR_SEG_ENABLE_A)) seg_enable_a_reg <= sfr_wdata;
      if (hit(ADDR_SEG_ENABLE_B)) seg_enable_b_reg <= sfr_wdata;
      if (hit(ADDR_CONFIG_X))     config_x_reg     <= sfr_wdata & MASK_CONFIG_X;
      if (hit(ADDR_MEM_POINTER))  mem_pointer_reg  <= sfr_wdata;
    end
  end

  // Flag set by a frame start wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      config_y_reg <= RESET_VALUE;
    end else begin
      if (hit(ADDR_CONFIG_Y)) begin
        config_y_reg <= sfr_wdata & MASK_CONFIG_Y;
      end
      if (frame_start && !config_y_reg[BIT_REFRESH]) begin
        config_y_reg[BIT_UPDATE_FINISHED] <= 1'b1;
      end
    end
  end

  // Clear holds while the bit is set, so writes to data are lost meanwhile
  always_ff @(posedge clk) begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      if (!resetn || main_config_reg[BIT_MEMORY_CLEAR]) begin
        mem_reg[i] <= RESET_VALUE;
      end else if (hit(ADDR_MEM_DATA) && mem_pointer_reg == 8'(i)) begin
        mem_reg[i] <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sfr_rdata <= RESET_VALUE;
    end else if (sfr_rd) begin
      case (sfr_addr)
        ADDR_MAIN_CONFIG:  sfr_rdata <= main_config_reg;
        ADDR_CLOCK_CONFIG: sfr_rdata <= clock_config_reg;
        ADDR_SEG_ENABLE_A: sfr_rdata <= seg_enable_a_reg;
        ADDR_SEG_ENABLE_B: sfr_rdata <= seg_enable_b_reg;
        ADDR_CONFIG_X:     sfr_rdata <= config_x_reg;
        ADDR_CONFIG_Y:     sfr_rdata <= config_y_reg;
        ADDR_MEM_POINTER:  sfr_rdata <= mem_pointer_reg;
        ADDR_MEM_DATA: begin
          if (mem_pointer_reg <= LAST_MEM_INDEX) begin
            sfr_rdata <= mem_reg[mem_pointer_reg[3:0]];
          end else begin
            sfr_rdata <= RESET_VALUE;
          end
        end
        default:           sfr_rdata <= RESET_VALUE;
      endcase
    end
  end

  // ************************************************************
  // Derived controls
  // ************************************************************
  lcdc_mux_type   mux_level;
  lcdc_blink_type blink_source;
  logic           display_active_next;

  assign mux_level    = lcdc_mux_type'(main_config_reg[BIT_MUX_HI:BIT_MUX_LO]);
  assign blink_source = lcdc_blink_type'(clock_config_reg[7:6]);

  // Sleep is a level from the power controller on this clock; no synchroniser
  assign display_active_next = main_config_reg[BIT_DRIVER_ON]
                             && !(sleep_power_mode
                                  && main_config_reg[BIT_SLEEP_OFF])
                             && (mux_level != MUX_RESERVED);

  // ************************************************************
  // Time base
  // ************************************************************
  logic [15:0] base_cnt_reg;
  logic [3:0]  slow_cnt_reg;
  logic        base_tick;
  logic        lcd_tick;

  assign base_tick = (base_cnt_reg == 16'(BASE_DIV_CYCLES - 1));
  assign lcd_tick  = base_tick
                   && (!main_config_reg[BIT_CLOCK_CHOICE]
                       || slow_cnt_reg == SLOW_PER_BASE);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      base_cnt_reg <= '0;
      slow_cnt_reg <= '0;
    end else begin
      base_cnt_reg <= base_tick ? '0 : base_cnt_reg + 16'h0001;
      if (base_tick) begin
        slow_cnt_reg <= slow_cnt_reg + 4'h1;
      end
    end
  end

  // ************************************************************
  // Common stepping and frames
  // ************************************************************
  logic [3:0] fd_cnt_reg;
  logic [1:0] common_idx_reg;
  logic       frame_pol_reg;
  logic       step;
  logic [1:0] last_common;
  logic [1:0] common_idx;

  // Frame divider 0 steps on every display tick, so the glass never sees a stuck common
  assign step        = lcd_tick && (fd_cnt_reg >= clock_config_reg[3:0]);
  assign last_common = 2'(mux_level);
  // Lowering the mux level live folds a stale index back to common 0
  assign common_idx  = (common_idx_reg > last_common) ? '0 : common_idx_reg;
  assign frame_start = step && (common_idx == last_common) && display_active_next;

  always_ff @(posedge clk) begin
    if (!resetn || !display_active_next) begin
      fd_cnt_reg     <= '0;
      common_idx_reg <= '0;
      frame_pol_reg  <= 1'b0;
    end else begin
      if (lcd_tick) begin
        fd_cnt_reg <= step ? '0 : fd_cnt_reg + 4'h1;
      end
      if (step) begin
        common_idx_reg <= (common_idx == last_common) ? '0
                        : common_idx + 2'h1;
      end
      if (frame_start && config_y_reg[BIT_FRAME_INVERT]) begin
        frame_pol_reg <= !frame_pol_reg;
      end
    end
  end

  // Data taken over only at frame start, never mid-frame, to avoid tearing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shadow_reg <= '0;
    end else if (frame_start && !config_y_reg[BIT_REFRESH]) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        shadow_reg[i*8 +: 8] <= mem_reg[i];
      end
    end
  end

  // ************************************************************
  // Blink
  // ************************************************************
  logic [12:0] blink_cnt_reg;
  logic        blink_phase_reg;
  logic [12:0] blink_half;
  logic        blink_visible;

  always_comb begin
    case (clock_config_reg[5:4])
      2'h0:    blink_half = HALF_1HZ;
      2'h1:    blink_half = HALF_HALFHZ;
      2'h2:    blink_half = HALF_THIRD;
      default: blink_half = HALF_FOURTH;
    endcase
    if (blink_source == BLINK_FIXED_2HZ) begin
      blink_half = HALF_2HZ;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !main_config_reg[BIT_BLINK_ON]) begin
      blink_cnt_reg   <= '0;
      blink_phase_reg <= 1'b1;
    end else if (base_tick) begin
      if (blink_cnt_reg >= blink_half - 13'h0001) begin
        blink_cnt_reg   <= '0;
        blink_phase_reg <= !blink_phase_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 13'h0001;
      end
    end
  end

  always_comb begin
    case (blink_source)
      BLINK_SOFT_OFF: blink_visible = 1'b0;
      BLINK_SOFT_ON:  blink_visible = 1'b1;
      default:        blink_visible = blink_phase_reg;
    endcase
    if (!main_config_reg[BIT_BLINK_ON]) begin
      blink_visible = 1'b1;
    end
  end

  // ************************************************************
  // Pin outputs
  // ************************************************************
  logic [FRONTPLANES-1:0] seg_en;
  logic [FRONTPLANES-1:0] seg_value;
  logic [COMMONS-1:0]     com_used;
  logic                   seg_pin_a_is_com;
  logic                   seg_pin_b_is_com;

  // Frontplane 16 shares enable bit 7 of the second enable register
  assign seg_en = {seg_enable_b_reg[7], seg_enable_b_reg, seg_enable_a_reg};

  assign seg_pin_b_is_com = (mux_level == MUX_THREE) || (mux_level == MUX_FOUR);
  assign seg_pin_a_is_com = (mux_level == MUX_FOUR);
  assign com_used = {seg_pin_a_is_com, seg_pin_b_is_com, 2'b11};

  generate
    for (genvar f = 0; f < FRONTPLANES; f++) begin : g_seg
      assign seg_value[f] = shadow_reg[f*COMMONS + int'(common_idx)];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!resetn || !display_active_next) begin
      drive <= '0;
    end else begin
      drive.common_on    <= 4'(1) << common_idx;
      drive.common_used  <= com_used;
      drive.segment_used <= seg_en;
      drive.segment_on   <= seg_value & seg_en & {FRONTPLANES{blink_visible}};
      drive.frame_invert <= frame_pol_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      analog <= '0;
    end else begin
      analog.display_active            <= display_active_next;
      analog.bias_third                <= main_config_reg[BIT_BIAS_THIRD];
      analog.display_clock_choice      <= main_config_reg[BIT_CLOCK_CHOICE];
      analog.external_ladder_select    <= config_x_reg[BIT_LADDER];
      analog.charge_pump_on            <= display_active_next
                                        && !config_x_reg[BIT_LADDER];
      analog.shared_pin_seg_or_common2 <= seg_pin_b_is_com;
      analog.shared_pin_seg_or_common3 <= seg_pin_a_is_com;
      analog.bias_level                <= config_x_reg[5:0];
    end
  end

endmodule : lcdc_driver

// file: lcdc_driver_checker.sv
`timescale 1ns/1ps
module lcdc_driver_checker
  import lcdc_pkg::*;
(
  input wire logic            clk,
  input wire logic            resetn,
  input wire logic [7:0]      sfr_addr,
  input wire logic [7:0]      sfr_wdata,
  input wire logic            sfr_wr,
  input wire logic            sfr_rd,
  input wire logic            sleep_power_mode,
  input wire logic [7:0]      sfr_rdata,
  input wire lcdc_drive_type  drive,
  input wire lcdc_analog_type analog
);
  // ****
  // Helpers
  // ****
  logic w_main;
  logic mapped;
  assign w_main = sfr_wr && sfr_addr == ADDR_MAIN_CONFIG;
  assign mapped = sfr_addr inside {ADDR_MAIN_CONFIG, ADDR_CLOCK_CONFIG, ADDR_SEG_ENABLE_A,
    ADDR_CONFIG_X, ADDR_MEM_POINTER, ADDR_MEM_DATA, ADDR_CONFIG_Y, ADDR_SEG_ENABLE_B};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****
  // Properties
  // ****
  reset_clears_a: assert property (disable iff (1'b0) !resetn |=> drive == '0 && analog == '0)
    else $error("outputs not cleared by reset");
  main_readback_a: assert property (
    w_main ##1 !sfr_wr ##1 (sfr_rd && sfr_addr == ADDR_MAIN_CONFIG)
    |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("main config read back wrong");
  unmapped_zero_a: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  enable_fields_a: assert property ((w_main && sfr_wdata[7] && sfr_wdata[1:0] != 2'h0
    && !sleep_power_mode) ##1 (!w_main && !sleep_power_mode) |=> analog.display_active
    && analog.bias_third == $past(sfr_wdata[2], 2)
    && analog.display_clock_choice == $past(sfr_wdata[3], 2))
    else $error("enable, bias or clock choice wrong");
  disable_off_a: assert property (
    w_main && !sfr_wdata[7] ##1 !w_main |=> !analog.display_active)
    else $error("display active while disabled");
  sleep_off_a: assert property ((w_main && sfr_wdata[4] && sleep_power_mode)
    ##1 (!w_main && sleep_power_mode) |=> !analog.display_active)
    else $error("display active in sleep with off bit");
  shared_pins_a: assert property ((w_main && sfr_wdata[7] && sfr_wdata[1:0] != 2'h0
    && !sleep_power_mode) ##1 (!w_main && !sleep_power_mode)
    |=> analog.shared_pin_seg_or_common2 == ($past(sfr_wdata[1:0], 2) != 2'h1)
    && analog.shared_pin_seg_or_common3 == ($past(sfr_wdata[1:0], 2) == 2'h3))
    else $error("shared pin roles wrong");
  reserved_idle_a: assert property (
    (w_main && sfr_wdata[1:0] == 2'h0) ##1 !w_main ##1 !w_main
    |=> drive == '0) else $error("drive active with reserved mux");
  commons_legal_a: assert property (drive.common_used != 4'h0 |-> $onehot(drive.common_on)
    && drive.common_used inside {4'h3, 4'h7, 4'hF}
    && (drive.common_on & ~drive.common_used) == 4'h0) else $error("common pattern bad");
  segments_enabled_a: assert property ((drive.segment_on & ~drive.segment_used) == 17'h0)
    else $error("segment driven without enable");
  pump_ladder_a: assert property (analog.charge_pump_on |-> analog.display_active
    && !analog.external_ladder_select) else $error("charge pump with ladder");
endmodule : lcdc_driver_checker

bind lcdc_driver lcdc_driver_checker i_lcdc_driver_checker (.clk(clk), .resetn(resetn),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sleep_power_mode(sleep_power_mode), .sfr_rdata(sfr_rdata), .drive(drive),
  .analog(analog));

// file: lcdc_driver_tb.sv
`timescale 1ns/1ps
module lcdc_driver_tb
  import lcdc_pkg::*;
;
  logic            clk = 1'b0;
  logic            resetn = 1'b0;
  logic [7:0]      sfr_addr = 8'h00;
  logic [7:0]      sfr_wdata = 8'h00;
  logic            sfr_wr = 1'b0;
  logic            sfr_rd = 1'b0;
  logic            sleep_power_mode = 1'b0;
  logic [7:0]      sfr_rdata;
  lcdc_drive_type  drive;
  lcdc_analog_type analog;
  int              bad_count = 0;
  int              tests_run = 0;
  int              cycles = 0;
  int              frames;
  int              glass_errs;
  int              f0;
  int              mem_q [$];
  logic [7:0]      rnd = 8'h41;
  logic [7:0]      got;
  logic [7:0]      regs [8] = '{ADDR_MAIN_CONFIG, ADDR_CLOCK_CONFIG, ADDR_SEG_ENABLE_A,
    ADDR_CONFIG_X, ADDR_MEM_POINTER, ADDR_MEM_DATA, ADDR_CONFIG_Y, ADDR_SEG_ENABLE_B};

  // ****
  // Design and glass, short base divider keeps frames quick
  // ****
  lcdc_driver #(.BASE_DIV_CYCLES(4)) i_lcdc_driver (.clk(clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sleep_power_mode(sleep_power_mode), .sfr_rdata(sfr_rdata), .drive(drive),
    .analog(analog));
  lcdc_glass i_lcdc_glass (.clk(clk), .drive(drive), .frames(frames), .errs(glass_errs));

  initial begin
    forever #20 clk = ~clk;
  end

  // ****
  // Tasks
  // ****
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    got = sfr_rdata;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // Whole run needs a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  // ****
  // Scenarios
  // ****
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(got, 8'h00);
    end
    foreach (regs[i]) begin
      if (i != 4 && i != 5) begin
        rnd = lfsr_next(rnd);
        wr(regs[i], rnd);
        rd(regs[i]);
        chk((i == 6) ? got & 8'hFD : got, rnd & ((i == 3) ? 8'h7F : (i == 6) ? 8'h41 : 8'hFF));
      end
    end
    rd(8'h50);
    chk(got, 8'h00);
    wr(ADDR_MAIN_CONFIG, 8'h00);
    wr(ADDR_CONFIG_Y, 8'h00);
    // Shortest frame divider so every window below sees whole frames
    wr(ADDR_CLOCK_CONFIG, 8'h00);
    for (int k = 0; k < 9; k++) begin
      rnd = lfsr_next(rnd);
      wr(ADDR_MEM_POINTER, 8'(k));
      wr(ADDR_MEM_DATA, rnd);
      mem_q.push_back(int'(rnd));
    end
    for (int k = 0; k < 10; k++) begin
      wr(ADDR_MEM_POINTER, 8'(k));
      rd(ADDR_MEM_DATA);
      chk(got, (k < 9) ? 8'(mem_q[k]) : 8'h00);
    end
    wr(ADDR_MAIN_CONFIG, 8'h40);
    wr(ADDR_MAIN_CONFIG, 8'h00);
    mem_q = '{0, 0, 0, 0, 0, 0, 0, 0, 0};
    wr(ADDR_MEM_POINTER, 8'h03);
    rd(ADDR_MEM_DATA);
    chk(got, 8'(mem_q[3]));
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MAIN_CONFIG, 8'h80 | 8'(m));
      idle(8);
      f0 = frames;
      idle(40);
      chk({7'h0, frames != f0}, {7'h0, m != 0});
      chk({4'h0, drive.common_used}, (m == 0) ? 8'h00 : 8'((1 << (m + 1)) - 1));
      if (m != 0) begin
        chk({6'h0, analog.shared_pin_seg_or_common3, analog.shared_pin_seg_or_common2},
          {6'h0, m == 3, m >= 2});
      end
    end
    wr(ADDR_CLOCK_CONFIG, 8'h03);
    idle(20);
    f0 = frames;
    idle(128);
    chk(8'(frames - f0), 8'h02);
    wr(ADDR_CLOCK_CONFIG, 8'h00);
    wr(ADDR_MAIN_CONFIG, 8'h8F);
    idle(4);
    chk({6'h0, analog.display_clock_choice, analog.bias_third}, 8'h03);
    wr(ADDR_MAIN_CONFIG, 8'h83);
    wr(ADDR_CONFIG_Y, 8'h00);
    idle(60);
    rd(ADDR_CONFIG_Y);
    chk(got, 8'h02);
    wr(ADDR_CONFIG_Y, 8'h01);
    idle(40);
    wr(ADDR_CONFIG_Y, 8'h01);
    idle(60);
    rd(ADDR_CONFIG_Y);
    chk(got, 8'h01);
    wr(ADDR_SEG_ENABLE_A, 8'hFF);
    wr(ADDR_SEG_ENABLE_B, 8'hFF);
    wr(ADDR_MEM_POINTER, 8'h00);
    wr(ADDR_MEM_DATA, 8'hFF);
    idle(40);
    chk(drive.segment_on[7:0], 8'h00);
    wr(ADDR_CONFIG_Y, 8'h00);
    idle(40);
    chk(drive.segment_on[7:0], 8'h03);
    chk(drive.segment_used[7:0], 8'hFF);
    wr(ADDR_SEG_ENABLE_A, 8'hFE);
    idle(4);
    chk(drive.segment_on[7:0], 8'h02);
    wr(ADDR_MAIN_CONFIG, 8'hA3);
    idle(4);
    chk(drive.segment_on[7:0], 8'h00);
    wr(ADDR_CLOCK_CONFIG, 8'h40);
    idle(4);
    chk(drive.segment_on[7:0], 8'h02);
    // Fixed blink toggles every 512 base ticks, 2048 cycles with the short divider
    wr(ADDR_MAIN_CONFIG, 8'h83);
    wr(ADDR_CLOCK_CONFIG, 8'h80);
    wr(ADDR_MAIN_CONFIG, 8'hA3);
    idle(1000);
    chk(drive.segment_on[7:0], 8'h02);
    idle(2000);
    chk(drive.segment_on[7:0], 8'h00);
    wr(ADDR_MAIN_CONFIG, 8'h83);
    wr(ADDR_CLOCK_CONFIG, 8'h00);
    wr(ADDR_CONFIG_X, 8'h40);
    idle(4);
    chk({6'h0, analog.external_ladder_select, analog.charge_pump_on}, 8'h02);
    wr(ADDR_CONFIG_X, 8'h00);
    idle(4);
    chk({6'h0, analog.external_ladder_select, analog.charge_pump_on}, 8'h01);
    // Reference keepalive is raised outside this block before sleep
    sleep_power_mode = 1'b1;
    wr(ADDR_MAIN_CONFIG, 8'h93);
    idle(4);
    chk({7'h0, analog.display_active}, 8'h00);
    wr(ADDR_MAIN_CONFIG, 8'h83);
    idle(4);
    chk({7'h0, analog.display_active}, 8'h01);
    sleep_power_mode = 1'b0;
    wr(ADDR_MAIN_CONFIG, 8'h03);
    idle(4);
    chk({7'h0, analog.display_active}, 8'h00);
    chk(8'(glass_errs), 8'h00);
    wr(ADDR_MAIN_CONFIG, 8'h83);
    resetn = 1'b0;
    idle(2);
    resetn = 1'b1;
    rd(ADDR_MAIN_CONFIG);
    chk(got, 8'h00);
    final_report();
  end
endmodule : lcdc_driver_tb

// file: lcdc_glass.sv
`timescale 1ns/1ps
module lcdc_glass
  import lcdc_pkg::*;
(
  input  wire logic           clk,
  input  wire lcdc_drive_type drive,
  output int                  frames = 0,
  output int                  errs = 0
);
  // ****
  // Passive glass: counts frames, flags illegal commons
  // ****
  logic [COMMONS-1:0] last_common = '0;
  always @(posedge clk) begin
    if (drive.common_used != 4'h0) begin
      if (!$onehot(drive.common_on) || (drive.common_on & ~drive.common_used) != 4'h0) begin
        errs <= errs + 1;
      end
      if (drive.common_on[0] && !last_common[0]) begin
        frames <= frames + 1;
      end
    end
    last_common <= drive.common_on;
  end
endmodule : lcdc_glass

// file: lcdc_pkg.sv
package lcdc_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_MAIN_CONFIG   = 8'h95;
  localparam logic [7:0] ADDR_CLOCK_CONFIG  = 8'h96;
  localparam logic [7:0] ADDR_SEG_ENABLE_A  = 8'h97;
  localparam logic [7:0] ADDR_CONFIG_X      = 8'h9C;
  localparam logic [7:0] ADDR_MEM_POINTER   = 8'hAC;
  localparam logic [7:0] ADDR_MEM_DATA      = 8'hAE;
  localparam logic [7:0] ADDR_CONFIG_Y      = 8'hB1;
  localparam logic [7:0] ADDR_SEG_ENABLE_B  = 8'hED;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_DRIVER_ON       = 7;
  localparam int BIT_MEMORY_CLEAR    = 6;
  localparam int BIT_BLINK_ON        = 5;
  localparam int BIT_SLEEP_OFF       = 4;
  localparam int BIT_CLOCK_CHOICE    = 3;
  localparam int BIT_BIAS_THIRD      = 2;
  localparam int BIT_MUX_HI          = 1;
  localparam int BIT_MUX_LO          = 0;
  localparam int BIT_LADDER          = 6;
  localparam int BIT_FRAME_INVERT    = 6;
  localparam int BIT_UPDATE_FINISHED = 1;
  localparam int BIT_REFRESH         = 0;

  localparam logic [7:0] MASK_CONFIG_X = 8'h7F;
  localparam logic [7:0] MASK_CONFIG_Y = 8'h43;
  localparam logic [7:0] RESET_VALUE   = 8'h00;

  // ************************************************************
  // Display memory and glass
  // ************************************************************
  localparam int FRONTPLANES = 17;
  localparam int COMMONS     = 4;
  localparam int MEM_BYTES   = 9;
  localparam int MEM_BITS    = MEM_BYTES * 8;
  localparam logic [7:0] LAST_MEM_INDEX = 8'h08;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int BASE_HZ       = 2048;
  localparam int SLOW_HZ       = 128;
  localparam int BASE_DIV      = CLK_HZ / BASE_HZ;
  localparam logic [3:0] SLOW_PER_BASE = 4'(BASE_HZ / SLOW_HZ - 1);
  // Blink half periods in base ticks
  localparam logic [12:0] HALF_2HZ    = 13'(BASE_HZ / 4);
  localparam logic [12:0] HALF_1HZ    = 13'(BASE_HZ / 2);
  localparam logic [12:0] HALF_HALFHZ = 13'(BASE_HZ);
  localparam logic [12:0] HALF_THIRD  = 13'(BASE_HZ * 3 / 2);
  localparam logic [12:0] HALF_FOURTH = 13'(BASE_HZ * 2);

  typedef enum logic [1:0] {
    MUX_RESERVED = 2'h0,
    MUX_TWO      = 2'h1,
    MUX_THREE    = 2'h2,
    MUX_FOUR     = 2'h3
  } lcdc_mux_type;

  typedef enum logic [1:0] {
    BLINK_SOFT_OFF = 2'h0,
    BLINK_SOFT_ON  = 2'h1,
    BLINK_FIXED_2HZ = 2'h2,
    BLINK_BY_RATE  = 2'h3
  } lcdc_blink_type;

  typedef struct packed {
    logic [COMMONS-1:0]     common_on;
    logic [COMMONS-1:0]     common_used;
    logic [FRONTPLANES-1:0] segment_on;
    logic [FRONTPLANES-1:0] segment_used;
    logic                   frame_invert;
  } lcdc_drive_type;

  typedef struct packed {
    logic display_active;
    logic bias_third;
    logic display_clock_choice;
    logic charge_pump_on;
    logic external_ladder_select;
    logic shared_pin_seg_or_common2;
    logic shared_pin_seg_or_common3;
    logic [5:0] bias_level;
  } lcdc_analog_type;

endpackage : lcdc_pkg
